// *** dv/cam_counter_access_asserts.sv ***
// Purpose: Concurrent checks on the ports of the counter access block.
// Assumes: Zero-wait APB; byte address is four times the register index.
// Notes:   Shadow flops track the started command, finish, done and master enable.
`timescale 1ns/1ns
`include "cam_cfg.svh"
module cam_counter_access_asserts
    import cam_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int NUM_LINKS = 8
) (
    // Clock, reset and APB.
    input wire logic                   mclk_i,
    input wire logic                   reset_i,
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire logic [ADDR_W-1:0]      paddr_i,
    input wire logic [31:0]            pwdata_i,
    input wire logic [31:0]            prdata_o,
    // Counter port.
    input wire logic                   cnt_req_o,
    input wire logic                   cnt_write_o,
    input wire logic                   cnt_irq_en_sel_o,
    input wire logic                   cnt_irq_en_o,
    input wire logic                   cnt_ack_i,
    // Interrupts.
    input wire logic [NUM_LINKS*8-1:0] link_status_i,
    input wire logic [NUM_LINKS*8-1:0] link_enable_i,
    input wire logic                   irq_n_o
);
// ============================================================================
// Shadow state
// ============================================================================
localparam logic [ADDR_W-1:0] A_CMD = ADDR_W'(`CAM_IDX_COMMAND * 4),
    A_MEN = ADDR_W'(`CAM_IDX_MST_ENABLE * 4), A_MST = ADDR_W'(`CAM_IDX_MST_STATUS * 4);
logic [NUM_LINKS-1:0] link_valid;
logic [NUM_LINKS-1:0] men_q;
logic [7:0]           cmd_q;
logic                 fin_q;
logic                 done_q;
wire wr_acc    = psel_i & penable_i & pwrite_i;
wire rd_acc    = psel_i & penable_i & ~pwrite_i;
wire cmd_wr    = wr_acc && (paddr_i == A_CMD);
wire idle      = ~cnt_req_o & ~fin_q;
wire good_code = (pwdata_i[1:0] == `CAM_CODE_VALUE) || (pwdata_i[1:0] == `CAM_CODE_IRQ_EN);
wire start     = cmd_wr & idle & good_code;
always_comb
begin
    for (int n = 0; n < NUM_LINKS; n++)
    begin
        link_valid[n] = |(link_status_i[n*8 +: 8] & link_enable_i[n*8 +: 8]);
    end
end
always_ff @(posedge mclk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        fin_q  <= 1'b0;
        done_q <= 1'b0;
        cmd_q  <= 8'h00;
        men_q  <= '0;
    end
    else
    begin
        fin_q  <= cnt_req_o & cnt_ack_i;
        done_q <= start ? 1'b0 : (fin_q ? 1'b1 : done_q);
        cmd_q  <= start ? pwdata_i[7:0] : cmd_q;
        men_q  <= (wr_acc && paddr_i == A_MEN) ? pwdata_i[NUM_LINKS-1:0] : men_q;
    end
end
// ============================================================================
// Properties
// ============================================================================
default clocking cb @(posedge mclk_i); endclocking
default disable iff (reset_i);
// A command is a setup cycle followed by an accepted access.
sequence cmd_start_s;
    psel_i & ~penable_i ##1 start;
endsequence
sequence ack_s;
    cnt_req_o & cnt_ack_i;
endsequence
start_req_a: assert property (cmd_start_s |=> cnt_req_o)
    else $error("valid command did not raise the counter request");
bad_code_a: assert property (cmd_wr && idle && !good_code |=> !cnt_req_o)
    else $error("forbidden command code started a transfer");
req_hold_a: assert property (cnt_req_o && !cnt_ack_i |=> cnt_req_o)
    else $error("counter request dropped before the answer");
ack_end_a: assert property (ack_s |=> !cnt_req_o [*2])
    else $error("counter request stayed after the answer");
dir_field_a: assert property (cnt_req_o |-> cnt_write_o == !cmd_q[2])
    else $error("transfer direction differs from the command");
ien_field_a: assert property (cnt_req_o |->
    cnt_irq_en_sel_o == (cmd_q[1:0] == `CAM_CODE_IRQ_EN) && cnt_irq_en_o == (cnt_irq_en_sel_o && cmd_q[3]))
    else $error("enable bit transfer fields are wrong");
done_read_a: assert property (rd_acc && paddr_i == A_CMD |-> prdata_o[7] == $past(done_q))
    else $error("done bit read back wrong");
status_read_a: assert property (rd_acc && paddr_i == A_MST |->
    prdata_o[NUM_LINKS-1:0] == $past(link_valid))
    else $error("master status does not follow the link requests");
irq_pin_a: assert property (irq_n_o == !(|(link_valid & men_q)))
    else $error("interrupt pin level is wrong");
endmodule // cam_counter_access_asserts

bind cam_counter_access cam_counter_access_asserts #(
    .ADDR_W(ADDR_W), .NUM_LINKS(NUM_LINKS)
) i_cam_asserts (
    .mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .cnt_req_o, .cnt_write_o, .cnt_irq_en_sel_o, .cnt_irq_en_o, .cnt_ack_i,
    .link_status_i, .link_enable_i, .irq_n_o
);

// *** dv/cam_counter_access_tb_top.sv ***
// Purpose: Self-checking bench for the counter access block.
// Assumes: Zero-wait APB slave; the bench answers the counter port itself.
// Notes:   Table rows cover plain register access, hand tests the rest.
`timescale 1ns/1ns
`include "cam_cfg.svh"
module cam_counter_access_tb_top import cam_pkg::*;;
typedef struct packed
{
    logic [11:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] expv;
    logic        err;
} cam_row_s;
localparam logic [11:0] A_CMD = 12'(`CAM_IDX_COMMAND * 4),
    A_MEN = 12'(`CAM_IDX_MST_ENABLE * 4), A_MST = 12'(`CAM_IDX_MST_STATUS * 4),
    A_SEL = 12'(`CAM_IDX_SELECT * 4), A_B3 = 12'(`CAM_IDX_BYTE3 * 4),
    A_B2 = 12'(`CAM_IDX_BYTE2 * 4), A_B1 = 12'(`CAM_IDX_BYTE1 * 4),
    A_EST = 12'(`CAM_IDX_EVT_STATUS * 4), A_ECL = 12'(`CAM_IDX_EVT_CLEAR * 4),
    A_EEN = 12'(`CAM_IDX_EVT_ENABLE * 4);
// Reset values, read-only status, misaligned and unmapped places.
localparam cam_row_s ROWS [11] = '{
    '{A_MEN, 1'b0, 32'h0, 32'h00, 1'b0}, '{A_MST, 1'b0, 32'h0, 32'h00, 1'b0},
    '{A_CMD, 1'b0, 32'h0, 32'h00, 1'b0}, '{A_MEN, 1'b1, 32'ha5, 32'h0, 1'b0},
    '{A_MEN, 1'b0, 32'h0, 32'ha5, 1'b0}, '{A_MST, 1'b1, 32'hff, 32'h0, 1'b0},
    '{A_MST, 1'b0, 32'h0, 32'h00, 1'b0}, '{12'h861, 1'b0, 32'h0, 32'h0, 1'b1},
    '{12'h004, 1'b0, 32'h0, 32'h0, 1'b1}, '{A_SEL, 1'b1, 32'h73, 32'h0, 1'b0},
    '{A_MEN, 1'b1, 32'h00, 32'h0, 1'b0}};
logic mclk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
logic [11:0] paddr_i;
logic [31:0] pwdata_i, prdata_o, r;
logic cnt_req_o, cnt_write_o, cnt_irq_en_sel_o, cnt_irq_en_o, cnt_ack_i, cnt_irq_en_i;
logic [7:0] cnt_select_o;
logic [23:0] cnt_wdata_o, cnt_rdata_i;
logic [63:0] link_status_i, link_enable_i;
logic irq_n_o, irq_o, e;
int bad_count = 0;
int comparisons = 0;
cam_counter_access i_dut (
    .mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .cnt_req_o, .cnt_write_o, .cnt_irq_en_sel_o, .cnt_select_o,
    .cnt_wdata_o, .cnt_irq_en_o, .cnt_ack_i, .cnt_rdata_i, .cnt_irq_en_i, .link_status_i,
    .link_enable_i, .irq_n_o, .irq_o
);
// ============================================================================
// Tasks
// ============================================================================
task automatic test_done();
    if (bad_count == 0 && comparisons > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
task automatic check(input logic [31:0] act, input logic [31:0] expv);
    comparisons++;
    if (act !== expv)
    begin
        bad_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, act, expv);
    end
endtask
task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    paddr_i   <= a;
    pwrite_i  <= w;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
endtask
task automatic rd_chk(input logic [11:0] a, input logic [31:0] expv);
    apb(a, 1'b0, 32'h0);
    check(r, expv);
endtask
task automatic wait_req();
    repeat (50) if (cnt_req_o !== 1'b1) @(posedge mclk_i);
    check({31'h0, cnt_req_o}, 32'h1);
endtask
// A released counter bus shows the inverse value, never the old one.
task automatic ack(input int stall, input logic [23:0] d, input logic ien);
    repeat (stall) @(posedge mclk_i);
    cnt_ack_i    <= 1'b1;
    cnt_rdata_i  <= d;
    cnt_irq_en_i <= ien;
    @(posedge mclk_i);
    cnt_ack_i    <= 1'b0;
    cnt_rdata_i  <= ~d;
    cnt_irq_en_i <= ~ien;
endtask
task automatic wait_done(input logic [31:0] expv);
    r = 32'h0;
    repeat (20) if (r[7] !== 1'b1) apb(A_CMD, 1'b0, 32'h0);
    check(r, expv);
endtask
// ============================================================================
// Stimulus
// ============================================================================
initial
begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
end
initial
begin
    repeat (5000) @(posedge mclk_i);
    bad_count++;
    test_done();
end
initial
begin
    {reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
    {cnt_ack_i, cnt_rdata_i, cnt_irq_en_i, link_status_i, link_enable_i} = '0;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (ROWS[i])
    begin
        apb(ROWS[i].addr, ROWS[i].wr, ROWS[i].wdata);
        if (!ROWS[i].wr) check(r, ROWS[i].expv);
        check({31'h0, e}, {31'h0, ROWS[i].err});
    end
    wr(A_CMD, 32'h0d);
    wait_req();
    check({29'h0, cnt_write_o, cnt_irq_en_sel_o, cnt_irq_en_o}, 32'h0);
    check({24'h0, cnt_select_o}, 32'h73);
    rd_chk(A_CMD, 32'h0d);
    wr(A_CMD, 32'h01);
    ack(2, 24'habcdef, 1'b0);
    wait_done(32'h8d);
    rd_chk(A_B3, 32'hab);
    rd_chk(A_B2, 32'hcd);
    rd_chk(A_B1, 32'hef);
    wr(A_B3, 32'h11);
    wr(A_B2, 32'h22);
    wr(A_B1, 32'h33);
    wr(A_CMD, 32'h01);
    wait_req();
    check({31'h0, cnt_write_o}, 32'h1);
    check({8'h0, cnt_wdata_o}, 32'h112233);
    ack(0, 24'h0, 1'b0);
    wait_done(32'h81);
    wr(A_CMD, 32'h0a);
    wait_req();
    check({30'h0, cnt_irq_en_sel_o, cnt_irq_en_o}, 32'h3);
    ack(1, 24'h0, 1'b0);
    wait_done(32'h8a);
    wr(A_CMD, 32'h06);
    wait_req();
    check({30'h0, cnt_write_o, cnt_irq_en_o}, 32'h0);
    ack(0, 24'h0, 1'b1);
    wait_done(32'h86);
    rd_chk(A_B1, 32'h01);
    wr(A_CMD, 32'h00);
    wr(A_CMD, 32'h03);
    @(posedge mclk_i);
    check({31'h0, cnt_req_o}, 32'h0);
    rd_chk(A_CMD, 32'h86);
    rd_chk(A_EST, 32'h3);
    check({31'h0, irq_o}, 32'h0);
    wr(A_EEN, 32'h2);
    @(posedge mclk_i);
    check({31'h0, irq_o}, 32'h1);
    wr(A_ECL, 32'h3);
    @(posedge mclk_i);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(A_EST, 32'h0);
    link_status_i <= 64'h0400_0000;
    link_enable_i <= 64'h0300_0000;
    rd_chk(A_MST, 32'h00);
    link_enable_i <= 64'h0400_0000;
    rd_chk(A_MST, 32'h08);
    check({31'h0, irq_n_o}, 32'h1);
    wr(A_MEN, 32'hf7);
    @(posedge mclk_i);
    check({31'h0, irq_n_o}, 32'h1);
    wr(A_MEN, 32'h08);
    @(posedge mclk_i);
    check({31'h0, irq_n_o}, 32'h0);
    link_status_i <= 64'h0;
    @(posedge mclk_i);
    check({31'h0, irq_n_o}, 32'h1);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd_chk(A_MEN, 32'h00);
    rd_chk(A_CMD, 32'h00);
    test_done();
end
endmodule // cam_counter_access_tb_top

// *** rtl/cam_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts of the counter access block.
// Assumes: Printed offsets are register indices; the byte address is four times the index.
// Notes:   Included by its bare name.
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH

// ============================================================================
// Register indices (byte address = index * 4)
// ============================================================================
`define CAM_IDX_BYTE3       10'h214
`define CAM_IDX_BYTE2       10'h215
`define CAM_IDX_BYTE1       10'h216
`define CAM_IDX_SELECT      10'h217
`define CAM_IDX_COMMAND     10'h207
`define CAM_IDX_MST_ENABLE  10'h218
`define CAM_IDX_MST_STATUS  10'h232
`define CAM_IDX_EVT_STATUS  10'h240
`define CAM_IDX_EVT_CLEAR   10'h241
`define CAM_IDX_EVT_ENABLE  10'h242

// ============================================================================
// Command register fields
// ============================================================================
`define CAM_CMD_CODE_LSB    0
`define CAM_CMD_CODE_MSB    1
`define CAM_CMD_DIR_BIT     2
`define CAM_CMD_IEVAL_BIT   3
`define CAM_CMD_RSVD_LSB    4
`define CAM_CMD_RSVD_MSB    6
`define CAM_CMD_DONE_BIT    7
`define CAM_CODE_RESERVED   2'h0
`define CAM_CODE_VALUE      2'h1
`define CAM_CODE_IRQ_EN     2'h2
`define CAM_CODE_UNUSED     2'h3

// ============================================================================
// Event bits and reset values
// ============================================================================
`define CAM_EVT_DONE_BIT    0
`define CAM_EVT_BADCMD_BIT  1
`define CAM_EVT_WIDTH       2
`define CAM_RST_BYTE        8'h00
`define CAM_RST_MST_ENABLE  8'h00
`define CAM_RST_EVT         2'h0
`define CAM_NUM_LINKS       8

`endif

// *** rtl/cam_counter_access.sv ***
// What this block does
// - Command code 01 moves a counter value, 10 its interrupt enable bit; 00, 11 forbidden.
// - Direction bit 0 writes holding registers into counter; 1 reads counter to them.
// - Bit 3 gives interrupt enable value, applied only for command code 10.
// - Bit 7 reads 1 when transfer finished, 0 pending; software writes 0 there.
// - Master status has one bit per link, 1 while that link requests.
// - Writes to master status are ignored and change nothing.
// - Master status is not latched; enable changes alter the pin at once.
// - Active-low pin is low when any requesting link has its master enable bit set.
// - A link requests when any link status bit meets its enable bit.
// - Select upper nibble picks counter type, lower nibble picks link or group.
// - Holding bytes feed counter writes and capture counter reads.
//
// Purpose: APB register bank driving indirect counter transfers and the link interrupt pin.
// Assumes: Zero-wait APB slave; counters answer on cnt_ack_i some cycles after a request.
// Notes:   Also raises a level interrupt from its own transfer events.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "cam_cfg.svh"
module cam_counter_access
    import cam_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int NUM_LINKS = `CAM_NUM_LINKS,
    parameter int CNT_W     = 24
) (
    // Clock and reset.
    input  wire logic                   mclk_i,
    input  wire logic                   reset_i,
    // APB slave.
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [ADDR_W-1:0]      paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Internal counter access port.
    output logic                        cnt_req_o,
    output logic                        cnt_write_o,
    output logic                        cnt_irq_en_sel_o,
    output logic      [7:0]             cnt_select_o,
    output logic      [CNT_W-1:0]       cnt_wdata_o,
    output logic                        cnt_irq_en_o,
    input  wire logic                   cnt_ack_i,
    input  wire logic [CNT_W-1:0]       cnt_rdata_i,
    input  wire logic                   cnt_irq_en_i,
    // Per-link interrupt sources.
    input  wire logic [NUM_LINKS*8-1:0] link_status_i,
    input  wire logic [NUM_LINKS*8-1:0] link_enable_i,
    // Interrupt outputs.
    output logic                        irq_n_o,
    output logic                        irq_o
);

    // ========================================================================
    // Register state
    // ========================================================================
    cam_state_e                 state;
    cam_state_e                 next_state;
    logic [7:0]                 byte3;
    logic [7:0]                 byte2;
    logic [7:0]                 byte1;
    logic [7:0]                 counter_select;
    logic [1:0]                 cmd_code;
    logic                       cmd_dir;
    logic                       cmd_ieval;
    logic [2:0]                 cmd_rsvd;
    logic                       done;
    logic [NUM_LINKS-1:0]       interrupt_master_enable;
    logic [NUM_LINKS-1:0]       interrupt_master_status;
    logic [`CAM_EVT_WIDTH-1:0]  evt_status;
    logic [`CAM_EVT_WIDTH-1:0]  evt_enable;
    logic [31:0]                next_prdata;
    logic                       next_slverr;

    // ========================================================================
    // APB decode
    // ========================================================================
    wire [9:0] word_idx   = paddr_i[11:2];
    wire       aligned    = (paddr_i[1:0] == 2'h0);
    wire       hit_byte3  = aligned && (word_idx == `CAM_IDX_BYTE3);
    wire       hit_byte2  = aligned && (word_idx == `CAM_IDX_BYTE2);
    wire       hit_byte1  = aligned && (word_idx == `CAM_IDX_BYTE1);
    wire       hit_select = aligned && (word_idx == `CAM_IDX_SELECT);
    wire       hit_cmd    = aligned && (word_idx == `CAM_IDX_COMMAND);
    wire       hit_men    = aligned && (word_idx == `CAM_IDX_MST_ENABLE);
    wire       hit_mst    = aligned && (word_idx == `CAM_IDX_MST_STATUS);
    wire       hit_evst   = aligned && (word_idx == `CAM_IDX_EVT_STATUS);
    wire       hit_evclr  = aligned && (word_idx == `CAM_IDX_EVT_CLEAR);
    wire       hit_even   = aligned && (word_idx == `CAM_IDX_EVT_ENABLE);
    wire       hit_any    = hit_byte3 | hit_byte2 | hit_byte1 | hit_select | hit_cmd
                          | hit_men | hit_mst | hit_evst | hit_evclr | hit_even;
    wire       setup      = psel_i && !penable_i;
    wire       access     = psel_i && penable_i;
    wire       wr_en      = access && pwrite_i && hit_any;
    wire       wr_byte3   = wr_en && hit_byte3;
    wire       wr_byte2   = wr_en && hit_byte2;
    wire       wr_byte1   = wr_en && hit_byte1;
    wire       wr_select  = wr_en && hit_select;
    wire       wr_cmd     = wr_en && hit_cmd;
    wire       wr_men     = wr_en && hit_men;
    wire       wr_evclr   = wr_en && hit_evclr;
    wire       wr_even    = wr_en && hit_even;

    // The slave never stalls; every answer comes in the access phase.
    assign pready_o = 1'b1;

    // ========================================================================
    // Command decode
    // ========================================================================
    wire [1:0] wr_code      = pwdata_i[`CAM_CMD_CODE_MSB:`CAM_CMD_CODE_LSB];
    wire       code_valid   = (wr_code == `CAM_CODE_VALUE) || (wr_code == `CAM_CODE_IRQ_EN);
    // A command issued while one is still running is dropped, since the
    // command fields of the first transfer would otherwise be overwritten.
    wire       busy         = (state != CAM_IDLE);
    wire       start        = wr_cmd && code_valid && !busy;
    wire       bad_cmd      = wr_cmd && (!code_valid || busy);
    wire       is_ie_xfer   = (cmd_code == `CAM_CODE_IRQ_EN);
    wire       cnt_read     = cmd_dir;
    wire       xfer_ack     = (state == CAM_REQ) && cnt_ack_i;
    wire       capture_val  = xfer_ack && cnt_read && !is_ie_xfer;
    wire       capture_ie   = xfer_ack && cnt_read && is_ie_xfer;
    wire       finish_evt   = (state == CAM_FINISH);

    // ========================================================================
    // Counter port
    // ========================================================================
    assign cnt_req_o        = (state == CAM_REQ);
    assign cnt_write_o      = (state == CAM_REQ) && !cmd_dir;
    assign cnt_irq_en_sel_o = is_ie_xfer;
    assign cnt_select_o     = counter_select;
    assign cnt_wdata_o      = {byte3, byte2, byte1};
    // The enable value is only meaningful for the enable transfer code.
    assign cnt_irq_en_o     = is_ie_xfer && cmd_ieval;

    // ========================================================================
    // Transfer sequencer
    // ========================================================================
    always_comb
    begin
        next_state = state;
        case (state)
            CAM_IDLE:
            begin
                if (start)
                begin
                    next_state = CAM_REQ;
                end
            end
            CAM_REQ:
            begin
                if (cnt_ack_i)
                begin
                    next_state = CAM_FINISH;
                end
            end
            CAM_FINISH:
            begin
                next_state = CAM_IDLE;
            end
            default:
            begin
                next_state = CAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state <= CAM_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ========================================================================
    // Command register
    // ========================================================================
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cmd_code  <= 2'h0;
            cmd_dir   <= 1'b0;
            cmd_ieval <= 1'b0;
            cmd_rsvd  <= 3'h0;
        end
        else if (start)
        begin
            cmd_code  <= wr_code;
            cmd_dir   <= pwdata_i[`CAM_CMD_DIR_BIT];
            cmd_ieval <= pwdata_i[`CAM_CMD_IEVAL_BIT];
            cmd_rsvd  <= pwdata_i[`CAM_CMD_RSVD_MSB:`CAM_CMD_RSVD_LSB];
        end
    end

    // Done drops on a started command and rises two cycles after the counter answers;
    // the written bit 7 itself is not stored.
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            done <= 1'b0;
        end
        else if (finish_evt)
        begin
            done <= 1'b1;
        end
        else if (start)
        begin
            done <= 1'b0;
        end
    end

    // ========================================================================
    // Holding bytes and select
    // ========================================================================
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            byte3 <= `CAM_RST_BYTE;
            byte2 <= `CAM_RST_BYTE;
            byte1 <= `CAM_RST_BYTE;
        end
        else if (capture_val)
        begin
            {byte3, byte2, byte1} <= cnt_rdata_i;
        end
        else if (capture_ie)
        begin
            byte1 <= {7'h00, cnt_irq_en_i};
        end
        else
        begin
            // Software writes land here; a running transfer would see them.
            if (wr_byte3) byte3 <= pwdata_i[7:0];
            if (wr_byte2) byte2 <= pwdata_i[7:0];
            if (wr_byte1) byte1 <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            counter_select <= `CAM_RST_BYTE;
        end
        else if (wr_select)
        begin
            counter_select <= pwdata_i[7:0];
        end
    end

    // ========================================================================
    // Master enable and link interrupt combining
    // ========================================================================
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            interrupt_master_enable <= `CAM_RST_MST_ENABLE;
        end
        else if (wr_men)
        begin
            interrupt_master_enable <= pwdata_i[NUM_LINKS-1:0];
        end
    end

    // Master status has no storage at all, so a write to it has nothing to change.
    cam_irq_combine #(
        .NUM_LINKS       (NUM_LINKS)
    ) u_irq_combine (
        .link_status_i   (link_status_i),
        .link_enable_i   (link_enable_i),
        .master_enable_i (interrupt_master_enable),
        .master_status_o (interrupt_master_status),
        .irq_n_o         (irq_n_o)
    );

    // ========================================================================
    // Block events
    // ========================================================================
    wire [`CAM_EVT_WIDTH-1:0] evt_set = {bad_cmd, finish_evt};
    wire [`CAM_EVT_WIDTH-1:0] evt_clr = wr_evclr ? pwdata_i[`CAM_EVT_WIDTH-1:0]
                                                 : {`CAM_EVT_WIDTH{1'b0}};

    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            evt_status <= `CAM_RST_EVT;
            evt_enable <= `CAM_RST_EVT;
        end
        else
        begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
            if (wr_even)
            begin
                evt_enable <= pwdata_i[`CAM_EVT_WIDTH-1:0];
            end
        end
    end

    assign irq_o = |(evt_status & evt_enable);

    // ========================================================================
    // Read data
    // ========================================================================
    wire [7:0] cmd_read = {done, cmd_rsvd, cmd_ieval, cmd_dir, cmd_code};

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (hit_byte3)  next_prdata[7:0] = byte3;
        if (hit_byte2)  next_prdata[7:0] = byte2;
        if (hit_byte1)  next_prdata[7:0] = byte1;
        if (hit_select) next_prdata[7:0] = counter_select;
        if (hit_cmd)    next_prdata[7:0] = cmd_read;
        if (hit_men)    next_prdata[NUM_LINKS-1:0] = interrupt_master_enable;
        if (hit_mst)    next_prdata[NUM_LINKS-1:0] = interrupt_master_status;
        if (hit_evst)   next_prdata[`CAM_EVT_WIDTH-1:0] = evt_status;
        if (hit_even)   next_prdata[`CAM_EVT_WIDTH-1:0] = evt_enable;
        next_slverr = !hit_any;
    end

    // Read data and error are caught in the setup cycle and held through access.
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (setup)
        begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : next_prdata;
            pslverr_o <= next_slverr;
        end
        else if (!psel_i)
        begin
            pslverr_o <= 1'b0;
        end
    end

endmodule // cam_counter_access

// *** rtl/cam_irq_combine.sv ***
// Purpose: Combines per-link status and enable bits into master status and the pin.
// Assumes: Per-link status and enable bits arrive synchronous to mclk_i.
// Notes:   Purely combinational, so mask changes reach the pin at once.
`timescale 1ns/1ns
module cam_irq_combine #(
    parameter int NUM_LINKS = 8
) (
    // Per-link interrupt sources, eight bits per link.
    input  wire logic [NUM_LINKS*8-1:0] link_status_i,
    input  wire logic [NUM_LINKS*8-1:0] link_enable_i,
    // Master enable from the register bank.
    input  wire logic [NUM_LINKS-1:0]   master_enable_i,
    // Results.
    output logic      [NUM_LINKS-1:0]   master_status_o,
    output logic                        irq_n_o
);

    // ========================================================================
    // Per-link request and pin
    // ========================================================================
    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++)
        begin : g_link
            // A request counts only when a status bit meets its enable bit.
            assign master_status_o[g] = |(link_status_i[g*8 +: 8] & link_enable_i[g*8 +: 8]);
        end
    endgenerate

    // Masked links never reach the pin; no latch keeps an old request alive.
    assign irq_n_o = ~(|(master_status_o & master_enable_i));

endmodule // cam_irq_combine

// *** rtl/cam_pkg.sv ***
// Purpose: Types shared by the counter access block.
// Assumes: Constants live in cam_cfg.svh.
// Notes:   Holds the transfer sequencer states only.
package cam_pkg;
    typedef enum logic [1:0]
    {
        CAM_IDLE,
        CAM_REQ,
        CAM_FINISH
    } cam_state_e;
endpackage
